// >>> ccd_pkg.sv
// Constants for the custom co-unit instruction decoder.
// Assumes one 250 MHz clock and a 32-bit AXI4-Lite register bus.
`default_nettype none
package ccd_pkg;
    // Opcode space
    localparam logic [1:0] QUAD_32BIT    = 2'h3;
    localparam logic [6:0] OPC_CUSTOM0   = 7'h0b;
    localparam logic [6:0] OPC_CUSTOM1   = 7'h2b;
    localparam logic [6:0] OPC_CUSTOM2   = 7'h5b;
    localparam logic [6:0] OPC_CUSTOM3   = 7'h7b;
    // Instruction field positions
    localparam int BIT_RESULT_WRITE = 14;
    localparam int BIT_SRC1_READ    = 13;
    localparam int BIT_SRC2_READ    = 12;
    localparam int BIT_ACCUM        = 31;
    localparam int BIT_FLOAT        = 30;
    localparam int BIT_PAIR         = 29;
    localparam int BIT_VEC_MASK     = 31;
    localparam int POS_VEC_RD_SRC   = 29;
    localparam int POS_VEC_OP1_SRC  = 27;
    localparam int POS_VEC_OP2_SRC  = 25;
    // Vector operand source codes
    localparam logic [1:0] VSRC_INT    = 2'h0;
    localparam logic [1:0] VSRC_FLOAT  = 2'h1;
    localparam logic [1:0] VSRC_VECTOR = 2'h2;
    // Register byte addresses
    localparam logic [3:0] ADDR_CONFIG = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    // Configuration register fields
    localparam int CFG_FLOAT     = 0;
    localparam int CFG_WIDE      = 1;
    localparam int CFG_PAIR_ACC  = 2;
    localparam int CFG_LARGE     = 3;
    localparam int CFG_DOUBLE    = 4;
    localparam int CFG_VECTOR    = 5;
    localparam int CFG_COMPRESS  = 6;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam int STATUS_WIDTH = 11;
    localparam logic [10:0] STATUS_RESET = 11'h000;
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [7:0]  cfg_reg;
        logic [10:0] stat_reg;
        logic        aw_got;
        logic        w_got;
        logic [3:0]  waddr;
        logic [7:0]  wbyte;
        logic        wlane0;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
    } ccd_state_s;

    localparam ccd_state_s STATE_RESET = '{
        cfg_reg: CONFIG_RESET, stat_reg: STATUS_RESET,
        aw_got: 1'b0, w_got: 1'b0, waddr: 4'h0, wbyte: 8'h00,
        wlane0: 1'b0, bvalid: 1'b0, bresp: 2'h0, rvalid: 1'b0,
        rresp: 2'h0, rdata: 32'h0000_0000};
endpackage
`default_nettype wire

// >>> ccd_decoder.sv
// Decoder for custom-opcode co-unit instructions, with a config register.
// Assumes instr is stable while instr_valid is high; bus is AXI4-Lite.
//
// Overview of operation
// - Four custom opcode groups hold co-unit instructions
// - Compressed extension claims custom-2 and custom-3
// - Result-write flag enables rd write-back
// - Source-read flags gate rs1 and rs2 reads
// - Bit 31 marks accumulate, rd as third source
// - Bit 30 selects float registers when configured
// - Bit 29 selects register pairs when configured
// - Other funct7 bits and fields are user-defined
// - Float instructions complete via multi-cycle path
// - Small core: float plus pair ignores pair
// - Large core: integer accumulate with pair unsupported
// - Vector cores do not use default decoding
// - Forbidden flag combinations are never asserted
// - Small core without pair-accumulate zeroes accumulate and source-pair flags
// - Without wide operands all pair flags are zero
// - Without float support all float flags are zero
// - Third operand: high half large, dedicated small
// - One-cycle pair write-back only on small core
// - Double float implies pair halves both ways
// - Unmodified decoder applies default field decoding
// - Vector operands: enable and one source flag
// - Vector valid, illegal and mask flags
`default_nettype none
module ccd_decoder (
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic [31:0] instr,
    input  wire logic        instr_valid,
    output logic             is_counit,
    output logic             result_write_flag,
    output logic             src1_enable,
    output logic             src2_enable,
    output logic             src1_float,
    output logic             src2_float,
    output logic             rd_float,
    output logic             src1_pair,
    output logic             src2_pair,
    output logic             rd_pair,
    output logic             rd_accum,
    output logic             illegal,
    output logic             need_multicycle,
    output logic             one_cycle_pair_ok,
    output logic             src3_on_high_half,
    output logic             src3_on_dedicated,
    output logic             issue,
    output logic             raise_exception,
    output logic             vec_op1_enable,
    output logic             vec_op1_from_float,
    output logic             vec_op1_from_int,
    output logic             vec_op1_from_vector,
    output logic             vec_op2_enable,
    output logic             vec_op2_from_float,
    output logic             vec_op2_from_int,
    output logic             vec_op2_from_vector,
    output logic             vec_rd_enable,
    output logic             vec_rd_from_float,
    output logic             vec_rd_from_int,
    output logic             vec_rd_from_vector,
    output logic             vec_masked,
    output logic             vec_valid_op,
    output logic             vec_illegal,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    ccd_pkg::ccd_state_s st_reg;
    ccd_pkg::ccd_state_s st_next;

    logic       cfg_float;
    logic       cfg_wide;
    logic       cfg_pair_acc;
    logic       cfg_large;
    logic       cfg_double;
    logic       cfg_vector;
    logic       cfg_compress;
    logic [6:0] opcode;
    logic       custom_hi;
    logic       bit_float;
    logic       bit_pair;
    logic       scalar_mode;
    logic       pair_raw;
    logic       acc_raw;
    logic       scalar_ilgl;
    logic [1:0] v_op1_src;
    logic [1:0] v_op2_src;
    logic [1:0] v_rd_src;
    logic       v_bad_src;

    assign cfg_float    = st_reg.cfg_reg[ccd_pkg::CFG_FLOAT];
    assign cfg_wide     = st_reg.cfg_reg[ccd_pkg::CFG_WIDE];
    assign cfg_pair_acc = st_reg.cfg_reg[ccd_pkg::CFG_PAIR_ACC];
    assign cfg_large    = st_reg.cfg_reg[ccd_pkg::CFG_LARGE];
    assign cfg_double   = st_reg.cfg_reg[ccd_pkg::CFG_DOUBLE];
    assign cfg_vector   = st_reg.cfg_reg[ccd_pkg::CFG_VECTOR];
    assign cfg_compress = st_reg.cfg_reg[ccd_pkg::CFG_COMPRESS];

    // Scalar decode, combinational from instr and the config register
    assign opcode    = instr[6:0];
    assign custom_hi = (opcode == ccd_pkg::OPC_CUSTOM2)
                     | (opcode == ccd_pkg::OPC_CUSTOM3);
    assign is_counit = (instr[1:0] == ccd_pkg::QUAD_32BIT)
                     & ((opcode == ccd_pkg::OPC_CUSTOM0)
                      | (opcode == ccd_pkg::OPC_CUSTOM1)
                      | (custom_hi & ~cfg_compress));
    assign scalar_mode = is_counit & ~cfg_vector;
    // Funct7 low bits and unused fields are not inspected
    assign result_write_flag = scalar_mode
                             & instr[ccd_pkg::BIT_RESULT_WRITE];
    assign src1_enable = scalar_mode
                       & instr[ccd_pkg::BIT_SRC1_READ];
    assign src2_enable = scalar_mode
                       & instr[ccd_pkg::BIT_SRC2_READ];
    assign bit_float = scalar_mode & cfg_float
                     & instr[ccd_pkg::BIT_FLOAT];
    assign src1_float = bit_float & src1_enable;
    assign src2_float = bit_float & src2_enable;
    assign rd_float   = bit_float & result_write_flag;
    // Float with pair set drops the pair bit unless double forces it
    assign bit_pair = scalar_mode & cfg_wide
                    & (bit_float ? cfg_double
                                 : instr[ccd_pkg::BIT_PAIR]);
    assign acc_raw  = scalar_mode & instr[ccd_pkg::BIT_ACCUM];
    assign pair_raw = bit_pair;
    // Small core without pair-accumulate never raises these
    assign rd_accum  = acc_raw & (cfg_large | cfg_pair_acc);
    // Float operands carry their own halves, so never a pair flag too
    assign src1_pair = pair_raw & src1_enable & ~bit_float
                     & (cfg_large | cfg_pair_acc);
    assign src2_pair = pair_raw & src2_enable & ~bit_float
                     & (cfg_large | cfg_pair_acc);
    // One-cycle rd may not be float, multi-cycle rd may not be pair
    assign rd_pair = pair_raw & result_write_flag & ~bit_float;
    assign need_multicycle = bit_float;
    assign one_cycle_pair_ok = rd_pair & ~cfg_large;
    assign src3_on_high_half = rd_accum & cfg_large;
    assign src3_on_dedicated = rd_accum & ~cfg_large;
    assign scalar_ilgl = scalar_mode & cfg_large & acc_raw
                       & instr[ccd_pkg::BIT_PAIR] & cfg_wide
                       & ~bit_float;

    // Vector decode
    assign v_op1_src = instr[ccd_pkg::POS_VEC_OP1_SRC +: 2];
    assign v_op2_src = instr[ccd_pkg::POS_VEC_OP2_SRC +: 2];
    assign v_rd_src  = instr[ccd_pkg::POS_VEC_RD_SRC +: 2];
    assign vec_op1_enable = is_counit & cfg_vector
                          & instr[ccd_pkg::BIT_SRC1_READ];
    assign vec_op2_enable = is_counit & cfg_vector
                          & instr[ccd_pkg::BIT_SRC2_READ];
    assign vec_rd_enable  = is_counit & cfg_vector
                          & instr[ccd_pkg::BIT_RESULT_WRITE];
    assign vec_op1_from_int    = vec_op1_enable
                               & (v_op1_src == ccd_pkg::VSRC_INT);
    assign vec_op1_from_float  = vec_op1_enable & cfg_float
                               & (v_op1_src == ccd_pkg::VSRC_FLOAT);
    assign vec_op1_from_vector = vec_op1_enable
                               & (v_op1_src == ccd_pkg::VSRC_VECTOR);
    assign vec_op2_from_int    = vec_op2_enable
                               & (v_op2_src == ccd_pkg::VSRC_INT);
    assign vec_op2_from_float  = vec_op2_enable & cfg_float
                               & (v_op2_src == ccd_pkg::VSRC_FLOAT);
    assign vec_op2_from_vector = vec_op2_enable
                               & (v_op2_src == ccd_pkg::VSRC_VECTOR);
    assign vec_rd_from_int     = vec_rd_enable
                               & (v_rd_src == ccd_pkg::VSRC_INT);
    assign vec_rd_from_float   = vec_rd_enable & cfg_float
                               & (v_rd_src == ccd_pkg::VSRC_FLOAT);
    assign vec_rd_from_vector  = vec_rd_enable
                               & (v_rd_src == ccd_pkg::VSRC_VECTOR);
    // An enabled operand with no usable source is illegal
    assign v_bad_src =
        (vec_op1_enable & ~(vec_op1_from_int | vec_op1_from_float
                            | vec_op1_from_vector))
      | (vec_op2_enable & ~(vec_op2_from_int | vec_op2_from_float
                            | vec_op2_from_vector))
      | (vec_rd_enable & ~(vec_rd_from_int | vec_rd_from_float
                           | vec_rd_from_vector));
    assign vec_illegal  = v_bad_src;
    assign vec_valid_op = is_counit & cfg_vector & ~v_bad_src;
    assign vec_masked   = vec_valid_op & instr[ccd_pkg::BIT_VEC_MASK];

    assign illegal = scalar_ilgl | vec_illegal;
    assign issue           = instr_valid & is_counit & ~illegal;
    assign raise_exception = instr_valid & illegal;

    // Register slave and status capture
    always_comb begin
        st_next = st_reg;
        if (instr_valid && is_counit) begin
            st_next.stat_reg = {vec_masked, vec_illegal, vec_valid_op,
                                pair_raw, bit_float, rd_accum,
                                src2_enable, src1_enable,
                                result_write_flag, illegal, is_counit};
        end
        if (s_axi_awvalid && s_axi_awready) begin
            st_next.aw_got = 1'b1;
            st_next.waddr  = s_axi_awaddr[3:0];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_next.w_got  = 1'b1;
            st_next.wbyte  = s_axi_wdata[7:0];
            st_next.wlane0 = s_axi_wstrb[0];
        end
        if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
            st_next.aw_got = 1'b0;
            st_next.w_got  = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp  = ccd_pkg::RESP_OKAY;
            if (st_reg.waddr == ccd_pkg::ADDR_CONFIG) begin
                if (st_reg.wlane0) begin
                    st_next.cfg_reg = st_reg.wbyte;
                end
            end else if (st_reg.waddr != ccd_pkg::ADDR_STATUS) begin
                st_next.bresp = ccd_pkg::RESP_SLVERR;
            end
        end
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end
        if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            st_next.rvalid = 1'b1;
            st_next.rresp  = ccd_pkg::RESP_OKAY;
            case (s_axi_araddr[3:0])
                ccd_pkg::ADDR_CONFIG: begin
                    st_next.rdata = {24'h000000, st_reg.cfg_reg};
                end
                ccd_pkg::ADDR_STATUS: begin
                    st_next.rdata = {21'h000000, st_reg.stat_reg};
                end
                default: begin
                    st_next.rdata = 32'h0000_0000;
                    st_next.rresp = ccd_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st_reg <= ccd_pkg::STATE_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign s_axi_awready = !st_reg.aw_got && !st_reg.bvalid;
    assign s_axi_wready  = !st_reg.w_got && !st_reg.bvalid;
    assign s_axi_bvalid  = st_reg.bvalid;
    assign s_axi_bresp   = st_reg.bresp;
    assign s_axi_arready = !st_reg.rvalid;
    assign s_axi_rvalid  = st_reg.rvalid;
    assign s_axi_rdata   = st_reg.rdata;
    assign s_axi_rresp   = st_reg.rresp;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    sequence s_cfg_write;
        st_reg.aw_got && st_reg.w_got && !st_reg.bvalid
        && st_reg.waddr == ccd_pkg::ADDR_CONFIG && st_reg.wlane0;
    endsequence

    a_cfg_takes_write: assert property (
        s_cfg_write |=> st_reg.cfg_reg == $past(st_reg.wbyte))
        else $error("config write not applied");
    a_bvalid_holds: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    a_pair_off_nowide: assert property (
        !cfg_wide |-> !(src1_pair || src2_pair || rd_pair))
        else $error("pair flag without wide operands");
    a_float_off_nocfg: assert property (
        !cfg_float |-> !(src1_float || src2_float || rd_float))
        else $error("float flag without float support");
    a_small_no_accpair: assert property (
        !cfg_large && !cfg_pair_acc
        |-> !(rd_accum || src1_pair || src2_pair))
        else $error("accumulate or pair flag on small core");
    a_src_combo_free: assert property (
        !(src1_enable && src1_pair && src1_float)
        && !(src2_enable && src2_pair && src2_float)
        && !(rd_pair && rd_float && rd_accum))
        else $error("forbidden flag combination");
    a_float_multicyc: assert property (
        rd_float |-> need_multicycle && !one_cycle_pair_ok)
        else $error("float result on one-cycle path");
    a_vector_no_scalar: assert property (
        cfg_vector |-> !(result_write_flag || src1_enable || src2_enable))
        else $error("default decode active on vector core");
    a_vec_one_source: assert property (
        vec_valid_op && vec_op1_enable
        |-> $onehot({vec_op1_from_float, vec_op1_from_int,
                     vec_op1_from_vector}))
        else $error("vector operand source not unique");
    a_ilgl_no_issue: assert property (
        instr_valid && illegal |-> raise_exception && !issue)
        else $error("illegal instruction issued");
    a_status_capture: assert property (
        instr_valid && is_counit
        |=> st_reg.stat_reg[2] == $past(result_write_flag))
        else $error("status did not capture decode");
    a_compress_custom: assert property (
        cfg_compress && instr[6:0] == ccd_pkg::OPC_CUSTOM3 |-> !is_counit)
        else $error("custom-3 decoded with compressed extension");
endmodule
`default_nettype wire

// >>> ccd_core_model.sv
// Core-side issue model: presents one instruction word for one cycle.
// Assumes the bench requests it on a rising edge with non-blocking writes.
`default_nettype none
module ccd_core_model (
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic [31:0] want_instr,
    input  wire logic        want_go,
    output logic [31:0]      instr,
    output logic             instr_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    // A released word is inverted every cycle so it never looks held
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            instr       <= 32'h0000_0000;
            instr_valid <= 1'b0;
        end else if (want_go) begin
            instr       <= want_instr;
            instr_valid <= 1'b1;
        end else begin
            instr       <= ~instr;
            instr_valid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> test_ccd_decoder.sv
// Self-checking bench for the co-unit instruction decoder.
// Assumes ccd_pkg, ccd_decoder and ccd_core_model are compiled first.
`default_nettype none
module test_ccd_decoder;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0, resetn = 1'b0, want_go = 1'b0, instr_valid;
    logic [31:0] instr, want_instr = '0, s_axi_awaddr = '0, s_axi_wdata = '0;
    logic [31:0] s_axi_araddr = '0, s_axi_rdata;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_bvalid;
    logic s_axi_awready, s_axi_wready, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic is_counit, result_write_flag, src1_enable, src2_enable, src1_float;
    logic src2_float, rd_float, src1_pair, src2_pair, rd_pair, rd_accum;
    logic illegal, need_multicycle, one_cycle_pair_ok, src3_on_high_half;
    logic src3_on_dedicated, issue, raise_exception, vec_op1_enable;
    logic vec_op1_from_float, vec_op1_from_int, vec_op1_from_vector;
    logic vec_op2_enable, vec_op2_from_float, vec_op2_from_int;
    logic vec_op2_from_vector, vec_rd_enable, vec_rd_from_float;
    logic vec_rd_from_int, vec_rd_from_vector, vec_masked, vec_valid_op;
    logic vec_illegal;
    int fail_count = 0;
    int comparisons = 0;

    always #2 clock = ~clock;

    ccd_core_model core_u (.clock, .resetn, .want_instr, .want_go, .instr,
        .instr_valid);
    ccd_decoder dut_u (.clock, .resetn, .instr, .instr_valid, .is_counit,
        .result_write_flag, .src1_enable, .src2_enable, .src1_float,
        .src2_float, .rd_float, .src1_pair, .src2_pair, .rd_pair, .rd_accum,
        .illegal, .need_multicycle, .one_cycle_pair_ok, .src3_on_high_half,
        .src3_on_dedicated, .issue, .raise_exception, .vec_op1_enable,
        .vec_op1_from_float, .vec_op1_from_int, .vec_op1_from_vector,
        .vec_op2_enable, .vec_op2_from_float, .vec_op2_from_int,
        .vec_op2_from_vector, .vec_rd_enable, .vec_rd_from_float,
        .vec_rd_from_int, .vec_rd_from_vector, .vec_masked, .vec_valid_op,
        .vec_illegal, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                          output logic [1:0] r);
        int n;
        logic ah, wh, bh;
        @(posedge clock);
        s_axi_awaddr <= {28'h0, a};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            #1;
            ah = s_axi_awvalid & s_axi_awready;
            wh = s_axi_wvalid & s_axi_wready;
            bh = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge clock);
            if (ah) s_axi_awvalid <= 1'b0;
            if (wh) s_axi_wvalid <= 1'b0;
            if (bh) begin
                s_axi_bready <= 1'b0;
                break;
            end
        end
        if (n == 40) begin
            fail_count++;
            tally_and_finish();
        end
    endtask

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        int n;
        logic ah, rh;
        @(posedge clock);
        s_axi_araddr <= {28'h0, a};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            #1;
            ah = s_axi_arvalid & s_axi_arready;
            rh = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clock);
            if (ah) s_axi_arvalid <= 1'b0;
            if (rh) begin
                s_axi_rready <= 1'b0;
                break;
            end
        end
        if (n == 40) begin
            fail_count++;
            tally_and_finish();
        end
    endtask

    task automatic cfg(input logic [7:0] v);
        logic [1:0] r;
        axi_wr(ccd_pkg::ADDR_CONFIG, {24'h0, v}, r);
    endtask

    // Word appears on the decoder one edge later; checks follow settling
    task automatic show(input logic [31:0] w);
        @(posedge clock);
        want_instr <= w;
        want_go <= 1'b1;
        @(posedge clock);
        want_go <= 1'b0;
        #1;
    endtask

    task automatic t_regs;
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(ccd_pkg::ADDR_CONFIG, d, r);
        chk("config reset", d, 32'h0000_0000);
        axi_rd(ccd_pkg::ADDR_STATUS, d, r);
        chk("status reset", d, 32'h0000_0000);
        cfg(8'h7f);
        axi_rd(ccd_pkg::ADDR_CONFIG, d, r);
        chk("config rw", d, 32'h0000_007f);
        axi_wr(ccd_pkg::ADDR_STATUS, 32'h0000_07ff, r);
        chk("status wr resp", r, ccd_pkg::RESP_OKAY);
        axi_rd(ccd_pkg::ADDR_STATUS, d, r);
        chk("status ro", d, 32'h0000_0000);
        axi_rd(4'h8, d, r);
        chk("unmapped resp", r, ccd_pkg::RESP_SLVERR);
        chk("unmapped data", d, 32'h0000_0000);
        $display("test regs done");
    endtask

    task automatic t_groups;
        logic [6:0] op [4];
        op = '{ccd_pkg::OPC_CUSTOM0, ccd_pkg::OPC_CUSTOM1,
               ccd_pkg::OPC_CUSTOM2, ccd_pkg::OPC_CUSTOM3};
        for (int c = 0; c < 2; c++) begin
            cfg(c ? 8'h40 : 8'h00);
            for (int g = 0; g < 4; g++) begin
                show({25'h0, op[g]});
                chk("is_counit", is_counit,
                    (c == 0) || (g < 2));
            end
        end
        show(32'h0000_0033);
        chk("standard op", is_counit, 0);
        show(32'h0000_000a);
        chk("short quadrant", is_counit, 0);
        $display("test groups done");
    endtask

    task automatic t_flags;
        cfg(8'h00);
        for (int k = 0; k < 8; k++) begin
            show({3'h0, 4'ha, 5'h03, 5'h07, 3'(k), 5'h09,
                  ccd_pkg::OPC_CUSTOM1});
            chk("rw flags", {result_write_flag, src1_enable, src2_enable},
                k);
        end
        show({3'h3, 22'h0000e0, ccd_pkg::OPC_CUSTOM0});
        chk("float pair off", {src1_float, src2_float, rd_float, src1_pair,
            src2_pair, rd_pair}, 0);
        $display("test flags done");
    endtask

    task automatic t_float_pair;
        logic [31:0] d;
        logic [1:0] r;
        cfg(8'h03);
        show({3'h3, 22'h0000e0, ccd_pkg::OPC_CUSTOM0});
        chk("float", {src1_float, src2_float, rd_float, src1_pair, src2_pair,
            rd_pair, need_multicycle}, 7'b1110001);
        show({3'h1, 22'h0000e0, ccd_pkg::OPC_CUSTOM0});
        chk("integer", {src1_float, src2_float, rd_float, need_multicycle},
            0);
        cfg(8'h06);
        show({3'h1, 22'h0000e0, ccd_pkg::OPC_CUSTOM0});
        chk("pairs", {src1_pair, src2_pair, rd_pair, one_cycle_pair_ok},
            4'hf);
        cfg(8'h02);
        show({3'h1, 22'h0000e0, ccd_pkg::OPC_CUSTOM0});
        chk("no pair acc", {src1_pair, src2_pair, rd_pair}, 1);
        cfg(8'h0a);
        show({3'h1, 22'h0000e0, ccd_pkg::OPC_CUSTOM0});
        chk("large 1cyc pair", one_cycle_pair_ok, 0);
        cfg(8'h17);
        show({3'h2, 22'h0000e0, ccd_pkg::OPC_CUSTOM0});
        chk("dbl src pair", {src1_pair, src2_pair, rd_pair}, 0);
        axi_rd(ccd_pkg::ADDR_STATUS, d, r);
        chk("dbl float pair", d[7:6], 2'b11);
        $display("test float pair done");
    endtask

    task automatic t_accum;
        cfg(8'h08);
        show({3'h4, 22'h0000e0, ccd_pkg::OPC_CUSTOM0});
        chk("large acc", {rd_accum, src3_on_high_half, src3_on_dedicated,
            issue, illegal}, 5'b11010);
        cfg(8'h04);
        show({3'h4, 22'h0000e0, ccd_pkg::OPC_CUSTOM0});
        chk("small acc", {rd_accum, src3_on_high_half, src3_on_dedicated,
            issue, illegal}, 5'b10110);
        show({3'h0, 22'h0000e0, ccd_pkg::OPC_CUSTOM0});
        chk("no acc", rd_accum, 0);
        cfg(8'h0a);
        show({3'h5, 22'h0000e0, ccd_pkg::OPC_CUSTOM0});
        chk("acc pair", {illegal, raise_exception, issue},
            3'b110);
        $display("test accum done");
    endtask

    task automatic t_vector;
        logic ok;
        cfg(8'h21);
        for (int c = 0; c < 4; c++) begin
            ok = (c != 3);
            show({1'b1, 2'h0, 2'(c), 2'(c), 10'h000, 3'h7, 5'h00,
                  ccd_pkg::OPC_CUSTOM0});
            chk("op1 src", {vec_op1_enable, vec_op1_from_int,
                vec_op1_from_float, vec_op1_from_vector},
                {1'b1, c == 0, c == 1, c == 2});
            chk("op2 src", {vec_op2_enable, vec_op2_from_int,
                vec_op2_from_float, vec_op2_from_vector},
                {1'b1, c == 0, c == 1, c == 2});
            chk("vec legal", {vec_valid_op, vec_illegal, vec_masked,
                illegal, raise_exception},
                {ok, !ok, ok, !ok, !ok});
            chk("no scalar", result_write_flag, 0);
        end
        $display("test vector done");
    endtask

    initial begin
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        t_regs();
        t_groups();
        t_flags();
        t_float_pair();
        t_accum();
        t_vector();
        tally_and_finish();
    end
endmodule
`default_nettype wire
